//--- test/dual_timer_chk.sv
// dual_timer_chk: port-level assertions for dual_timer
// assumes binding onto every dual_timer instance
`timescale 1ns/1ps

module dual_timer_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWriteData,
    input wire logic sfrRead,
    input wire logic [7:0] sfrReadData,
    input wire logic timer0Vector,
    input wire logic timer0Irq,
    input wire logic timer1Irq,
    input wire logic extIrq0,
    input wire logic extIrq1,
    input wire logic timer1OverflowPulse
);
    // reset is not a disable here: it is the cause under test
    AST_RST_OUTS: assert property (@(posedge clk) srst |=>
        !timer0Irq && !timer1Irq && !extIrq0 && !extIrq1 && !timer1OverflowPulse
        && sfrReadData == 8'h00) else $error("outputs not cleared by reset");
    AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (srst)
        sfrRead && (sfrAddr < 8'h88 || sfrAddr > 8'h8E) |=> sfrReadData == 8'h00)
        else $error("unmapped read not zero");
    AST_CKSEL_ZERO: assert property (@(posedge clk) disable iff (srst)
        sfrRead && sfrAddr == 8'h8E |=> (sfrReadData & 8'hE4) == 8'h00)
        else $error("unused clock select bits read nonzero");
    AST_RD_HOLD: assert property (@(posedge clk) disable iff (srst)
        !sfrRead |=> $stable(sfrReadData)) else $error("read data moved without read");
    AST_MODE_RW: assert property (@(posedge clk) disable iff (srst)
        sfrWrite && sfrAddr == 8'h89 ##1 sfrRead && !sfrWrite && sfrAddr == 8'h89
        |=> sfrReadData == $past(sfrWriteData, 2)) else $error("mode readback wrong");
    AST_CKSEL_RW: assert property (@(posedge clk) disable iff (srst)
        sfrWrite && sfrAddr == 8'h8E ##1 sfrRead && !sfrWrite && sfrAddr == 8'h8E
        |=> sfrReadData == ($past(sfrWriteData, 2) & 8'h1B))
        else $error("clock select readback wrong");
    // two zero writes: timers stopped before the second, so no set can win
    AST_FLAG_CLR: assert property (@(posedge clk) disable iff (srst)
        sfrWrite && sfrAddr == 8'h88 && sfrWriteData == 8'h00 ##1
        sfrWrite && sfrAddr == 8'h88 && sfrWriteData == 8'h00
        |-> ##2 !timer0Irq && !timer1Irq) else $error("flags not cleared");
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (srst)
        sfrWrite && sfrAddr == 8'h88 && sfrWriteData[5] ##1 !timer0Vector && !sfrWrite
        |-> ##1 timer0Irq) else $error("written flag not shown");
endmodule // dual_timer_chk

bind dual_timer dual_timer_chk u_chk (.clk(clk), .srst(srst), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWriteData(sfrWriteData), .sfrRead(sfrRead),
    .sfrReadData(sfrReadData), .timer0Vector(timer0Vector), .timer0Irq(timer0Irq),
    .timer1Irq(timer1Irq), .extIrq0(extIrq0), .extIrq1(extIrq1),
    .timer1OverflowPulse(timer1OverflowPulse));

//--- test/pin_model.sv
// pin_model: far-side count pins, gate pins and external clock
// assumes the bench calls its tasks from one process, 3 ns after an edge
`timescale 1ns/1ps

module pin_model (
    input wire logic clk,
    output logic countPinA,
    output logic countPinB,
    output logic gateInputAN,
    output logic gateInputBN,
    output logic extClk
);
    // idle: pins pulled high, external clock parked low between bursts
    initial begin
        countPinA = 1'b1;
        countPinB = 1'b1;
        gateInputAN = 1'b1;
        gateInputBN = 1'b1;
        extClk = 1'b0;
    end

    // falling edge, each level held three cycles
    task automatic pulse(input bit b);
        if (b) countPinB = 1'b0;
        else countPinA = 1'b0;
        repeat (3) @(posedge clk);
        #3;
        countPinA = 1'b1;
        countPinB = 1'b1;
        repeat (3) @(posedge clk);
        #3;
    endtask

    task automatic set_gate(input bit b, input logic v);
        if (b) gateInputBN = v;
        else gateInputAN = v;
    endtask

    // period 100 ns, slower than clk, each level longer than a clk period
    task automatic ext_burst(input int n);
        repeat (n) begin
            #50 extClk = 1'b1;
            #50 extClk = 1'b0;
        end
    endtask
endmodule // pin_model

//--- test/tb_dual_timer_split_mode_regs.sv
// tb_dual_timer_split_mode_regs: directed scenarios for dual_timer
// assumes pin_model on the pins; inputs move 3 ns after a rising edge
`timescale 1ns/1ps

module tb_dual_timer_split_mode_regs import timer_pkg::*;;
    logic clk, srst, sfrWrite, sfrRead, timer0Vector, timer1Vector;
    logic extIrq0Vector, extIrq1Vector, countPinA, countPinB, gateInputAN;
    logic gateInputBN, extClk, timer0Irq, timer1Irq, extIrq0, extIrq1, t1Pulse;
    logic [7:0] sfrAddr, sfrWriteData, sfrReadData;
    int err_count = 0;
    int n_checks = 0;

    dual_timer dut (.clk(clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrWriteData(sfrWriteData), .sfrRead(sfrRead), .sfrReadData(sfrReadData),
        .timer0Vector(timer0Vector), .timer1Vector(timer1Vector),
        .extIrq0Vector(extIrq0Vector), .extIrq1Vector(extIrq1Vector),
        .countPinA(countPinA), .countPinB(countPinB), .gateInputAN(gateInputAN),
        .gateInputBN(gateInputBN), .extClk(extClk), .timer0Irq(timer0Irq),
        .timer1Irq(timer1Irq), .extIrq0(extIrq0), .extIrq1(extIrq1),
        .timer1OverflowPulse(t1Pulse));
    pin_model pins (.clk(clk), .countPinA(countPinA), .countPinB(countPinB),
        .gateInputAN(gateInputAN), .gateInputBN(gateInputBN), .extClk(extClk));

    // free-running 25 MHz clock
    always #20 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #3;
    endtask

    // one write; the strobe drops and an edge passes before the next request
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n = 1);
        sfrAddr = a;
        sfrWriteData = d;
        sfrWrite = 1'b1;
        cyc(n);
        sfrWrite = 1'b0;
        cyc(1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        sfrAddr = a;
        sfrRead = 1'b1;
        cyc(1);
        sfrRead = 1'b0;
        cyc(1);
        cmp(n, e, sfrReadData);
    endtask

    // write immediately followed by a read of the same place
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        sfrAddr = a;
        sfrWriteData = d;
        sfrWrite = 1'b1;
        cyc(1);
        sfrWrite = 1'b0;
        sfrRead = 1'b1;
        cyc(1);
        sfrRead = 1'b0;
        cyc(1);
        cmp("readback", e, sfrReadData);
    endtask

    task automatic s_regs();
        for (int i = 0; i < 9; i++) rdc(8'h87 + 8'(i), 8'h00, "reset");
        wrrd(ADDR_TIMER_MODE, 8'hA5, 8'hA5);
        for (int i = 0; i < 4; i++) wrrd(8'h8A + 8'(i), 8'h5A + 8'(i), 8'h5A + 8'(i));
        wrrd(ADDR_CLOCK_SELECT, 8'hFF, 8'h1B);
        wr(ADDR_TIMER_MODE, 8'h00);
    endtask

    // 16-bit wrap on the system clock, then vector and software clears
    task automatic s_ovf();
        wr(ADDR_CLOCK_SELECT, 8'h08);
        wr(ADDR_TIMER_MODE, 8'h01);
        wr(ADDR_TIMER0_LOW, 8'hFE);
        wr(ADDR_TIMER0_HIGH, 8'hFF);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        // the stop write of zero meets the wrap edge: the set must survive
        wr(ADDR_TIMER_CONTROL, 8'h00);
        cmp("t0 flag", 8'h01, 8'(timer0Irq));
        rdc(ADDR_TIMER0_HIGH, 8'h00, "carry");
        timer0Vector = 1'b1;
        cyc(1);
        timer0Vector = 1'b0;
        cyc(2);
        cmp("t0 vector", 8'h00, 8'(timer0Irq));
        wr(ADDR_TIMER_CONTROL, 8'h20);
        cmp("t0 sw set", 8'h01, 8'(timer0Irq));
        wr(ADDR_TIMER_CONTROL, 8'h00, 2);
        cmp("t0 sw clear", 8'h00, 8'(timer0Irq));
    endtask

    // pin-counted auto-reload, then gating and both interrupt types
    task automatic s_pins();
        wr(ADDR_TIMER_MODE, 8'h06);
        wr(ADDR_TIMER0_HIGH, 8'h10);
        wr(ADDR_TIMER0_LOW, 8'hFF);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        pins.pulse(0);
        cmp("reload flag", 8'h01, 8'(timer0Irq));
        rdc(ADDR_TIMER0_LOW, 8'h10, "reload low");
        rdc(ADDR_TIMER0_HIGH, 8'h10, "reload high");
        wr(ADDR_TIMER_MODE, 8'h0D);
        wr(ADDR_TIMER0_LOW, 8'h00);
        pins.set_gate(0, 1'b0);
        cyc(4);
        cmp("level irq", 8'h01, 8'(extIrq0));
        pins.pulse(0);
        rdc(ADDR_TIMER0_LOW, 8'h00, "gated off");
        pins.set_gate(0, 1'b1);
        cyc(4);
        cmp("level irq off", 8'h00, 8'(extIrq0));
        pins.pulse(0);
        rdc(ADDR_TIMER0_LOW, 8'h01, "gated on");
        wr(ADDR_TIMER_CONTROL, 8'h01);
        pins.set_gate(0, 1'b0);
        cyc(4);
        pins.set_gate(0, 1'b1);
        cyc(4);
        cmp("edge irq", 8'h01, 8'(extIrq0));
        extIrq0Vector = 1'b1;
        cyc(1);
        extIrq0Vector = 1'b0;
        cyc(2);
        cmp("edge vector", 8'h00, 8'(extIrq0));
        wr(ADDR_TIMER_CONTROL, 8'h00);
        pins.set_gate(1, 1'b0);
        cyc(4);
        cmp("level irq1", 8'h01, 8'(extIrq1));
        pins.set_gate(1, 1'b1);
        cyc(4);
        cmp("level irq1 off", 8'h00, 8'(extIrq1));
    endtask

    task automatic s_split();
        int i;
        wr(ADDR_CLOCK_SELECT, 8'h18);
        wr(ADDR_TIMER1_LOW, 8'h00);
        wr(ADDR_TIMER1_HIGH, 8'hFF);
        wr(ADDR_TIMER0_HIGH, 8'hFE);
        wr(ADDR_TIMER0_LOW, 8'h00);
        wr(ADDR_TIMER_MODE, 8'h07);
        for (i = 0; i < 80 && t1Pulse !== 1'b1; i++) cyc(1);
        cmp("t1 pulse", 8'h01, 8'(t1Pulse));
        if (t1Pulse !== 1'b1) end_sim();
        cmp("t1 no flag", 8'h00, 8'(timer1Irq));
        wr(ADDR_TIMER_MODE, 8'h37);
        wr(ADDR_TIMER1_LOW, 8'h55);
        cyc(5);
        rdc(ADDR_TIMER1_LOW, 8'h55, "t1 halted");
        wr(ADDR_TIMER_CONTROL, 8'h40);
        cyc(4);
        cmp("high flag", 8'h01, 8'(timer1Irq));
        rdc(ADDR_TIMER0_LOW, 8'h00, "low idle");
        timer1Vector = 1'b1;
        cyc(1);
        timer1Vector = 1'b0;
        cyc(2);
        cmp("t1 vector", 8'h00, 8'(timer1Irq));
        wr(ADDR_TIMER_CONTROL, 8'h50);
        pins.pulse(0);
        rdc(ADDR_TIMER0_LOW, 8'h01, "low pin");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wr(ADDR_TIMER_MODE, 8'h01);
    endtask

    // exactly 96 running cycles, a whole number of periods of every ratio
    task automatic s_presc();
        logic [7:0] e, g;
        for (int i = 0; i < 3; i++) begin
            e = (i == 0) ? 8'd8 : (i == 1) ? 8'd24 : 8'd2;
            wr(ADDR_CLOCK_SELECT, 8'(i));
            wr(ADDR_TIMER0_LOW, 8'h00);
            wr(ADDR_TIMER_CONTROL, 8'h10);
            cyc(94);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rdc(ADDR_TIMER0_LOW, 8'h00 + e, "prescale");
            g = sfrReadData;
            cmp("prescale range", 8'h01, 8'(g + 8'd1 - e <= 8'd2));
        end
        wr(ADDR_CLOCK_SELECT, 8'h03);
        wr(ADDR_TIMER0_LOW, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        pins.ext_burst(16);
        cyc(6);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rdc(ADDR_TIMER0_LOW, 8'h02, "ext div");
    endtask

    initial begin
        {clk, sfrWrite, sfrRead, timer0Vector, timer1Vector} = 5'h00;
        {extIrq0Vector, extIrq1Vector} = 2'h0;
        {sfrAddr, sfrWriteData} = 16'h0000;
        srst = 1'b1;
        cyc(5);
        srst = 1'b0;
        s_regs();
        s_ovf();
        s_pins();
        s_split();
        s_presc();
        end_sim();
    end
endmodule // tb_dual_timer_split_mode_regs

//--- verilog/dual_timer.sv
// dual_timer: two legacy counter/timers with control, mode, count and clock registers
// assumes a byte-wide register port and vector acknowledges from the cpu on clk;
// count pins, gate pins and extClk are asynchronous and are synchronised here
`timescale 1ns/1ps

module dual_timer import timer_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWriteData,
    input wire logic sfrRead,
    output logic [7:0] sfrReadData,
    input wire logic timer0Vector,
    input wire logic timer1Vector,
    input wire logic extIrq0Vector,
    input wire logic extIrq1Vector,
    input wire logic countPinA,
    input wire logic countPinB,
    input wire logic gateInputAN,
    input wire logic gateInputBN,
    input wire logic extClk,
    output logic timer0Irq,
    output logic timer1Irq,
    output logic extIrq0,
    output logic extIrq1,
    output logic timer1OverflowPulse
);

    typedef struct packed {
        logic [7:0] timerControl;
        logic [7:0] timerMode;
        logic [7:0] timer0LowByte;
        logic [7:0] timer1LowByte;
        logic [7:0] timer0HighByte;
        logic [7:0] timer1HighByte;
        logic [7:0] clockSelect;
        logic [2:0] pinASync;
        logic [2:0] pinBSync;
        logic [2:0] gateASync;
        logic [2:0] gateBSync;
        logic t1Pulse;
        logic [7:0] readData;
    } state_s;

    state_s s;
    state_s next_s;
    logic prescaleTick;

    // one increment of a timer in modes 0..2: {overflow, high, low}
    function automatic logic [16:0] stepCount(input logic [1:0] mode, input logic [7:0] lo,
                                              input logic [7:0] hi);
        logic [12:0] sum13;
        logic [15:0] sum16;
        logic [16:0] result;
        sum13 = {hi, lo[4:0]} + 13'd1;
        sum16 = {hi, lo} + 16'd1;
        result = {1'b0, hi, lo};
        unique case (mode)
            // upper low-byte bits are left as they were
            MODE_13BIT: result = {&{hi, lo[4:0]}, sum13[12:5], lo[7:5], sum13[4:0]};
            MODE_16BIT: result = {&{hi, lo}, sum16};
            // wrap reloads from the unchanged high byte
            MODE_AUTORELOAD: result = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'd1};
            MODE_SPLIT: result = {1'b0, hi, lo};
        endcase
        return result;
    endfunction

    // decoded mode fields
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split;
    // synchronised pin events and levels
    logic fallA;
    logic fallB;
    logic gateALevel;
    logic gateBLevel;
    // count sources and run qualifiers
    logic tick0;
    logic tick1;
    logic tickHigh0;
    logic run0;
    logic run1;
    logic runHigh0;
    // stepped counts and flag events
    logic [16:0] step0;
    logic [16:0] step1;
    logic ovf0;
    logic ovf1;
    logic ovfHigh0;
    logic setTf0;
    logic setTf1;
    logic setIe0;
    logic setIe1;

    // falling edge on a synchronised vector: previous high, current low
    function automatic logic fallEdge(input logic [2:0] sync);
        return sync[2] & ~sync[1];
    endfunction

    always_comb begin
        next_s = s;
        // pins pass two flip-flops; stage 2 only keeps the previous value for edges
        // stage 0 may still be settling, so only stages 1 and 2 feed any logic
        next_s.pinASync = {s.pinASync[1:0], countPinA};
        next_s.pinBSync = {s.pinBSync[1:0], countPinB};
        next_s.gateASync = {s.gateASync[1:0], gateInputAN};
        next_s.gateBSync = {s.gateBSync[1:0], gateInputBN};
        fallA = s.pinASync[2] & ~s.pinASync[1];
        fallB = s.pinBSync[2] & ~s.pinBSync[1];
        gateALevel = s.gateASync[1];
        gateBLevel = s.gateBSync[1];

        mode0 = s.timerMode[TIMER0_NIBBLE + NIBBLE_MODE_LSB +: 2];
        mode1 = s.timerMode[TIMER1_NIBBLE + NIBBLE_MODE_LSB +: 2];
        split = (mode0 == MODE_SPLIT);

        // pin edges or clock source; clock choice ignored in counter function
        tick0 = s.timerMode[TIMER0_NIBBLE + NIBBLE_COUNT_SELECT] ? fallA :
                (s.clockSelect[TIMER0_CLOCK_CHOICE] | prescaleTick);
        // timer 1 cannot count pin edges while timer 0 is split
        tick1 = (s.timerMode[TIMER1_NIBBLE + NIBBLE_COUNT_SELECT] & ~split) ? fallB :
                (s.clockSelect[TIMER1_CLOCK_CHOICE] | prescaleTick);
        // split high byte is a timer on system or prescaled clock
        tickHigh0 = s.clockSelect[TIMER0_CLOCK_CHOICE] | prescaleTick;

        // run bit enables; gating requires the gate pin high
        run0 = s.timerControl[TIMER0_RUN] &
               (~s.timerMode[TIMER0_NIBBLE + NIBBLE_GATING] | gateALevel);
        // mode 3 halts timer 1; under split its mode alone runs it
        if (mode1 == MODE_SPLIT) begin
            run1 = 1'b0;
        end else if (split) begin
            run1 = 1'b1;
        end else begin
            run1 = s.timerControl[TIMER1_RUN] &
                   (~s.timerMode[TIMER1_NIBBLE + NIBBLE_GATING] | gateBLevel);
        end
        // split high byte runs under timer 1's run bit
        runHigh0 = split & s.timerControl[TIMER1_RUN];

        step0 = stepCount(mode0, s.timer0LowByte, s.timer0HighByte);
        step1 = stepCount(mode1, s.timer1LowByte, s.timer1HighByte);
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        ovfHigh0 = 1'b0;

        // counting advances the held value, and a wrap clears it or reloads it from the high byte
        if (run0 & tick0) begin
            if (split) begin
                // low byte as an independent 8-bit counter
                next_s.timer0LowByte = s.timer0LowByte + 8'd1;
                ovf0 = &s.timer0LowByte;
            end else begin
                {ovf0, next_s.timer0HighByte, next_s.timer0LowByte} = step0;
            end
        end
        if (runHigh0 & tickHigh0) begin
            // high byte counts on its own
            next_s.timer0HighByte = s.timer0HighByte + 8'd1;
            ovfHigh0 = &s.timer0HighByte;
        end
        if (run1 & tick1) begin
            {ovf1, next_s.timer1HighByte, next_s.timer1LowByte} = step1;
        end
        // timer 1 overflow still offered to baud and converter consumers
        next_s.t1Pulse = ovf1;

        // hardware sets; split high byte drives timer 1's flag; not timer 1
        setTf0 = ovf0;
        setTf1 = ovfHigh0 | (ovf1 & ~split);
        // falling edge when type is 1
        setIe0 = fallEdge(s.gateASync);
        setIe1 = fallEdge(s.gateBSync);

        // software writes override counting in the same cycle
        if (sfrWrite) begin
            unique case (sfrAddr)
                ADDR_TIMER_CONTROL: next_s.timerControl = sfrWriteData;
                ADDR_TIMER_MODE: next_s.timerMode = sfrWriteData;
                ADDR_TIMER0_LOW: next_s.timer0LowByte = sfrWriteData;
                ADDR_TIMER1_LOW: next_s.timer1LowByte = sfrWriteData;
                ADDR_TIMER0_HIGH: next_s.timer0HighByte = sfrWriteData;
                ADDR_TIMER1_HIGH: next_s.timer1HighByte = sfrWriteData;
                ADDR_CLOCK_SELECT: next_s.clockSelect = sfrWriteData & CLOCK_SELECT_MASK;
                default: ;
            endcase
        end

        if (timer0Vector) begin
            next_s.timerControl[TIMER0_OVERFLOW_FLAG] = 1'b0;
        end
        if (timer1Vector) begin
            next_s.timerControl[TIMER1_OVERFLOW_FLAG] = 1'b0;
        end
        // vector clear only in edge mode
        if (extIrq0Vector & s.timerControl[EXT_IRQ0_TYPE]) begin
            next_s.timerControl[EXT_IRQ0_FLAG] = 1'b0;
        end
        if (extIrq1Vector & s.timerControl[EXT_IRQ1_TYPE]) begin
            next_s.timerControl[EXT_IRQ1_FLAG] = 1'b0;
        end

        // a lost overflow is worse than a late clear, so the set path comes last
        // sets applied last so they win over any clear
        if (setTf0) begin
            next_s.timerControl[TIMER0_OVERFLOW_FLAG] = 1'b1;
        end
        if (setTf1) begin
            next_s.timerControl[TIMER1_OVERFLOW_FLAG] = 1'b1;
        end
        // level mode follows the inverted pin; edge mode is sticky
        if (!next_s.timerControl[EXT_IRQ0_TYPE]) begin
            next_s.timerControl[EXT_IRQ0_FLAG] = ~gateALevel;
        end else if (setIe0) begin
            next_s.timerControl[EXT_IRQ0_FLAG] = 1'b1;
        end
        if (!next_s.timerControl[EXT_IRQ1_TYPE]) begin
            next_s.timerControl[EXT_IRQ1_FLAG] = ~gateBLevel;
        end else if (setIe1) begin
            next_s.timerControl[EXT_IRQ1_FLAG] = 1'b1;
        end

        // read data is captured one cycle after the read strobe; unmapped reads 0
        if (sfrRead) begin
            unique case (sfrAddr)
                ADDR_TIMER_CONTROL: next_s.readData = s.timerControl;
                ADDR_TIMER_MODE: next_s.readData = s.timerMode;
                ADDR_TIMER0_LOW: next_s.readData = s.timer0LowByte;
                ADDR_TIMER1_LOW: next_s.readData = s.timer1LowByte;
                ADDR_TIMER0_HIGH: next_s.readData = s.timer0HighByte;
                ADDR_TIMER1_HIGH: next_s.readData = s.timer1HighByte;
                ADDR_CLOCK_SELECT: next_s.readData = s.clockSelect & CLOCK_SELECT_MASK;
                default: begin
                    next_s.readData = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.timerControl <= RESET_TIMER_CONTROL;
            s.timerMode <= RESET_TIMER_MODE;
            s.timer0LowByte <= RESET_COUNT;
            s.timer1LowByte <= RESET_COUNT;
            s.timer0HighByte <= RESET_COUNT;
            s.timer1HighByte <= RESET_COUNT;
            s.clockSelect <= RESET_CLOCK_SELECT;
            s.pinASync <= 3'h7;
            s.pinBSync <= 3'h7;
            s.gateASync <= 3'h7;
            s.gateBSync <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    // prescaled tick, external clock synchronised inside
    timer_prescaler prescaler (
        .clk(clk),
        .srst(srst),
        .prescaleField(s.clockSelect[PRESCALE_LSB +: 2]),
        .extClk(extClk),
        .prescaleTick(prescaleTick)
    );

    // outputs straight from state flip-flops
    assign sfrReadData = s.readData;
    assign timer0Irq = s.timerControl[TIMER0_OVERFLOW_FLAG];
    assign timer1Irq = s.timerControl[TIMER1_OVERFLOW_FLAG];
    assign extIrq0 = s.timerControl[EXT_IRQ0_FLAG];
    assign extIrq1 = s.timerControl[EXT_IRQ1_FLAG];
    assign timer1OverflowPulse = s.t1Pulse;

endmodule // dual_timer

//--- verilog/timer_pkg.sv
// timer_pkg: shared constants for the dual counter/timer block
// assumes a byte-wide special-function register port on the system clock
package timer_pkg;

    // special-function register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8E;

    // reset values
    localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RESET_TIMER_MODE = 8'h00;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam logic [7:0] RESET_CLOCK_SELECT = 8'h00;

    // timer_control bit positions
    localparam int TIMER1_OVERFLOW_FLAG = 7;
    localparam int TIMER1_RUN = 6;
    localparam int TIMER0_OVERFLOW_FLAG = 5;
    localparam int TIMER0_RUN = 4;
    localparam int EXT_IRQ1_FLAG = 3;
    localparam int EXT_IRQ1_TYPE = 2;
    localparam int EXT_IRQ0_FLAG = 1;
    localparam int EXT_IRQ0_TYPE = 0;

    // timer_mode fields: timer 1 in the upper nibble, timer 0 in the lower
    localparam int TIMER1_NIBBLE = 4;
    localparam int TIMER0_NIBBLE = 0;
    localparam int NIBBLE_GATING = 3;
    localparam int NIBBLE_COUNT_SELECT = 2;
    localparam int NIBBLE_MODE_LSB = 0;

    // mode field encodings
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_AUTORELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // clock_select fields; bits 7..5 and 2 are unimplemented
    localparam int TIMER1_CLOCK_CHOICE = 4;
    localparam int TIMER0_CLOCK_CHOICE = 3;
    localparam int PRESCALE_LSB = 0;
    localparam logic [7:0] CLOCK_SELECT_MASK = 8'h1B;

    // prescale field encodings and divide ratios
    localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
    localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
    localparam logic [1:0] PRESCALE_EXT8 = 2'h3;
    localparam logic [5:0] SYS_DIVIDE_12 = 6'd12;
    localparam logic [5:0] SYS_DIVIDE_4 = 6'd4;
    localparam logic [5:0] SYS_DIVIDE_48 = 6'd48;
    localparam logic [2:0] EXT_DIVIDE_8_LAST = 3'd7;

endpackage

//--- verilog/timer_prescaler.sv
// timer_prescaler: one-cycle tick at the prescaled timer rate
// assumes extClk is asynchronous and each of its levels outlasts one clk period
`timescale 1ns/1ps

module timer_prescaler import timer_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] prescaleField,
    input wire logic extClk,
    output logic prescaleTick
);

    typedef struct packed {
        logic [5:0] sysCount;
        logic [2:0] extSync;
        logic [2:0] extCount;
        logic tick;
    } state_s;

    state_s s;
    state_s next_s;
    logic [5:0] divide;
    logic extRise;

    // pick the divide ratio; the external path is handled by edge counting
    always_comb begin
        next_s = s;
        divide = SYS_DIVIDE_12;
        unique case (prescaleField)
            PRESCALE_DIV12: divide = SYS_DIVIDE_12;
            PRESCALE_DIV4: divide = SYS_DIVIDE_4;
            PRESCALE_DIV48: divide = SYS_DIVIDE_48;
            PRESCALE_EXT8: divide = SYS_DIVIDE_12;
        endcase
        // limitation: each extClk level must outlast one clk period or an edge is missed
        // synchronised external clock: stage 0 is read only by stage 1
        next_s.extSync = {s.extSync[1:0], extClk};
        extRise = s.extSync[1] & ~s.extSync[2];
        next_s.tick = 1'b0;
        if (prescaleField == PRESCALE_EXT8) begin
            next_s.sysCount = 6'd0;
            if (extRise) begin
                next_s.extCount = s.extCount + 3'd1;
                next_s.tick = (s.extCount == EXT_DIVIDE_8_LAST);
            end
        end else begin
            next_s.extCount = 3'd0;
            if (s.sysCount >= divide - 6'd1) begin
                next_s.sysCount = 6'd0;
                next_s.tick = 1'b1;
            end else begin
                next_s.sysCount = s.sysCount + 6'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prescaleTick = s.tick;

endmodule // timer_prescaler
